// ---- hdl/sfd_sfr_decode.sv ----
`timescale 1ns/1ns
// Operation
// - Direct access 0x80-0xFF goes to special registers
// - Bit access only at addresses ending 0/8
// - Page register bits 7:1 read zero, ignored
// - Short external move takes high byte from page
// - Page bit set selects 0x0100-0x01FF
// - Pointer moves ignore upper 7 address bits
// - Indirect access above 0x7F hits upper RAM
module sfd_sfr_decode #(
    parameter int ONCHIP_EXTERNAL_RAM_AW = sfd_pkg::SFD_ONCHIP_EXTERNAL_RAM_AW
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire sfd_pkg::sfd_acc_t  acc,
    input  wire logic [7:0]         periph_rdata,
    input  wire sfd_pkg::sfd_xmov_t xmov,
    output sfd_pkg::sfd_route_t     route,
    output logic [7:0]              rdata,
    output logic                    page_select_bit,
    output logic [ONCHIP_EXTERNAL_RAM_AW-1:0]      onchip_external_ram_addr,
    output logic [15:0]             onchip_external_ram_full_addr,
    output logic                    onchip_external_ram_valid
);

    sfd_pkg::sfd_dec_st_t st;
    sfd_pkg::sfd_dec_st_t next_st;

    logic in_sfr_space;
    logic direct_sfr;
    logic indirect_hi;
    logic occupied;
    logic is_page;
    logic bit_bad;

    // Address classification of the request in flight
    always_comb begin
        in_sfr_space = sfd_pkg::sfd_in_sfr(acc.addr);
        direct_sfr   = acc.valid && !acc.indirect && in_sfr_space;
        indirect_hi  = acc.valid && acc.indirect && in_sfr_space;
        occupied     = sfd_pkg::sfd_occupied(acc.addr);
        is_page      = (acc.addr == sfd_pkg::SFD_PAGE_ADDR);
        bit_bad      = acc.bit_op && !sfd_pkg::sfd_bit_ok(acc.addr);
    end

    always_comb begin
        next_st       = st;
        next_st.route = '0;
        next_st.rdata = sfd_pkg::SFD_ZERO_BYTE;
        if (acc.valid) begin
            if (!in_sfr_space) begin
                next_st.route.lo_ram = 1'b1;
            end else if (indirect_hi) begin
                // Same addresses as the special registers, but a separate RAM
                next_st.route.hi_ram = 1'b1;
            end else if (bit_bad) begin
                // Bit access to a byte-only register is refused and has no effect
                next_st.route.sfr         = 1'b1;
                next_st.route.bit_refused = 1'b1;
            end else if (!occupied) begin
                // Unoccupied: read zero, write dropped
                next_st.route.sfr      = 1'b1;
                next_st.route.reserved = 1'b1;
            end else if (is_page) begin
                next_st.route.sfr      = 1'b1;
                next_st.route.page_hit = 1'b1;
                if (acc.write) begin
                    // Only the page bit is stored; upper bits are don't care
                    next_st.page = acc.wdata[sfd_pkg::SFD_PAGE_BIT];
                end else begin
                    next_st.rdata = {sfd_pkg::SFD_PAGE_UNUSED, st.page};
                end
            end else begin
                next_st.route.sfr    = direct_sfr;
                next_st.route.periph = 1'b1;
                if (!acc.write) begin
                    next_st.rdata = periph_rdata;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st       <= '0;
            st.page  <= sfd_pkg::SFD_PAGE_RESET[sfd_pkg::SFD_PAGE_BIT];
        end else begin
            st <= next_st;
        end
    end

    assign route           = st.route;
    assign rdata           = st.rdata;
    assign page_select_bit = st.page;

    sfd_onchip_external_ram_addr #(
        .ONCHIP_EXTERNAL_RAM_AW (ONCHIP_EXTERNAL_RAM_AW)
    ) i_sfd_onchip_external_ram_addr (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .xmov           (xmov),
        .page           (st.page),
        .onchip_external_ram_addr      (onchip_external_ram_addr),
        .onchip_external_ram_full_addr (onchip_external_ram_full_addr),
        .onchip_external_ram_valid     (onchip_external_ram_valid)
    );

    direct_sfr_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.indirect && acc.addr[7] |=> route.sfr && !route.hi_ram && !route.lo_ram)
        else $error("direct upper access not routed to special registers");

    indirect_ram_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && acc.indirect && acc.addr[7] |=> route.hi_ram && !route.sfr)
        else $error("indirect upper access not routed to upper RAM");

    lower_ram_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.addr[7] |=> route.lo_ram && !route.sfr && !route.hi_ram)
        else $error("lower address not routed to lower RAM");

    bit_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.indirect && acc.bit_op && acc.addr[7] && acc.addr[2:0] != 3'h0
        |=> route.bit_refused && !route.periph && !route.page_hit)
        else $error("bit access to byte-only register not refused");

    bit_allow_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.indirect && acc.bit_op && acc.addr[7] && acc.addr[2:0] == 3'h0
        |=> !route.bit_refused)
        else $error("bit access to bit-addressable register refused");

    page_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && acc.write && !acc.indirect && !acc.bit_op && acc.addr == 8'hAA
        |=> page_select_bit == $past(acc.wdata[0]))
        else $error("page bit not taken from write data bit 0");

    page_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.write && !acc.indirect && !acc.bit_op && acc.addr == 8'hAA
        |=> rdata == {7'h00, $past(page_select_bit)})
        else $error("page register read value wrong");

    reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.reserved |-> rdata == 8'h00)
        else $error("reserved address read not zero");

    reserved_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && acc.write && !acc.indirect && !acc.bit_op && acc.addr[7] && !sfd_pkg::sfd_occupied(acc.addr)
        |=> route.reserved && $stable(page_select_bit))
        else $error("reserved write changed state");

    page_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(acc.valid && acc.write && !acc.indirect && !acc.bit_op && acc.addr == 8'hAA)
        |=> $stable(page_select_bit))
        else $error("page bit changed without a page write");

    periph_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.write && !acc.indirect && !acc.bit_op && acc.addr[7]
        && sfd_pkg::sfd_occupied(acc.addr) && acc.addr != 8'hAA
        |=> route.periph && rdata == $past(periph_rdata))
        else $error("peripheral read not passed through");

    idle_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        !acc.valid
        |=> route == 7'h00 && rdata == 8'h00)
        else $error("outputs not quiet without a request");

    write_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && acc.write
        |=> rdata == 8'h00)
        else $error("read data not zero after a write");

    route_one_a: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0({route.lo_ram, route.hi_ram, route.sfr}))
        else $error("more than one target space selected");

    hi_ram_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.hi_ram
        |-> rdata == 8'h00 && !route.periph && !route.page_hit && !route.reserved)
        else $error("upper RAM access touched register space");

    refused_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.bit_refused
        |-> route.sfr && rdata == 8'h00 && !route.reserved && !route.periph)
        else $error("refused bit access had an effect");

    page_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.page_hit
        |-> rdata[7:1] == 7'h00)
        else $error("page register upper bits not zero");

    short_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        xmov.valid && xmov.short_addr
        |=> onchip_external_ram_full_addr[15:8] == {7'h00, $past(page_select_bit)})
        else $error("short move high byte not the page bit");

    indirect_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && acc.indirect && acc.addr[7]
        |=> $stable(page_select_bit) && !route.page_hit)
        else $error("indirect access reached the page register");

    bit_page_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc.valid && !acc.indirect && acc.bit_op && acc.addr == 8'hAA
        |=> route.bit_refused && $stable(page_select_bit))
        else $error("bit access to page register not refused");

    reserved_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.reserved
        |-> route.sfr && !route.periph && !route.page_hit && !route.lo_ram)
        else $error("reserved access reached a register");

    lower_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        route.lo_ram
        |-> rdata == 8'h00 && !route.reserved && !route.bit_refused)
        else $error("lower RAM access touched register space");

    move_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        xmov.valid
        |=> onchip_external_ram_valid)
        else $error("external move not answered");

    move_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !xmov.valid
        |=> !onchip_external_ram_valid)
        else $error("external move answer without a request");

endmodule

// ---- hdl/sfd_pkg.sv ----
package sfd_pkg;

    // Special register space seen by direct addressing
    localparam logic [7:0]   SFD_SFR_LOW      = 8'h80;
    localparam logic [7:0]   SFD_SFR_HIGH     = 8'hFF;
    localparam logic [7:0]   SFD_LOWER_TOP    = 8'h7F;

    // Bit-addressable registers have the low three address bits at this value
    localparam logic [2:0]   SFD_BIT_ROW_LOW  = 3'h0;

    // Page register
    localparam logic [7:0]   SFD_PAGE_ADDR    = 8'hAA;
    localparam logic [7:0]   SFD_PAGE_RESET   = 8'h00;
    localparam int           SFD_PAGE_BIT     = 0;
    localparam logic [6:0]   SFD_PAGE_UNUSED  = 7'h00;

    // External RAM: 512 bytes, so 9 address bits are kept out of 16
    localparam int           SFD_ONCHIP_EXTERNAL_RAM_AW      = 9;
    localparam int           SFD_XADDR_W      = 16;
    localparam logic [6:0]   SFD_XHIGH_ZERO   = 7'h00;

    // Occupied special registers, one bit per address 0x80..0xFF, index = addr[6:0]
    localparam logic [127:0] SFD_OCCUPIED = {
        8'hFF, 8'hCF, 8'hFF, 8'hDF, 8'h1F, 8'hF3, 8'h3D, 8'h7F,
        8'h7F, 8'hCE, 8'h07, 8'h7F, 8'hAB, 8'hFF, 8'hFF, 8'h8F
    };

    localparam logic [7:0]   SFD_ZERO_BYTE    = 8'h00;

    typedef struct packed {
        logic       valid;
        logic       indirect;
        logic       bit_op;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfd_acc_t;

    typedef struct packed {
        logic lo_ram;
        logic hi_ram;
        logic sfr;
        logic periph;
        logic reserved;
        logic bit_refused;
        logic page_hit;
    } sfd_route_t;

    typedef struct packed {
        logic        valid;
        logic        short_addr;
        logic [7:0]  low;
        logic [15:0] ptr;
    } sfd_xmov_t;

    typedef struct packed {
        logic       page;
        sfd_route_t route;
        logic [7:0] rdata;
    } sfd_dec_st_t;

    typedef struct packed {
        logic        valid;
        logic        short_addr;
        logic [15:0] full;
    } sfd_xa_st_t;

    function automatic logic sfd_bit_ok(input logic [7:0] addr);
        sfd_bit_ok = (addr[2:0] == SFD_BIT_ROW_LOW);
    endfunction

    function automatic logic sfd_occupied(input logic [7:0] addr);
        sfd_occupied = SFD_OCCUPIED[addr[6:0]];
    endfunction

    function automatic logic sfd_in_sfr(input logic [7:0] addr);
        sfd_in_sfr = (addr >= SFD_SFR_LOW) && (addr <= SFD_SFR_HIGH);
    endfunction

endpackage

// ---- hdl/sfd_onchip_external_ram_addr.sv ----
`timescale 1ns/1ns
module sfd_onchip_external_ram_addr #(
    parameter int ONCHIP_EXTERNAL_RAM_AW = sfd_pkg::SFD_ONCHIP_EXTERNAL_RAM_AW
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire sfd_pkg::sfd_xmov_t xmov,
    input  wire logic               page,
    output logic [ONCHIP_EXTERNAL_RAM_AW-1:0]      onchip_external_ram_addr,
    output logic [15:0]             onchip_external_ram_full_addr,
    output logic                    onchip_external_ram_valid
);

    sfd_pkg::sfd_xa_st_t st;
    sfd_pkg::sfd_xa_st_t next_st;

    always_comb begin
        next_st            = st;
        next_st.valid      = xmov.valid;
        next_st.short_addr = xmov.short_addr;
        if (xmov.valid) begin
            if (xmov.short_addr) begin
                // High byte comes from the page register; only its low bit can be set
                next_st.full = {sfd_pkg::SFD_XHIGH_ZERO, page, xmov.low};
            end else begin
                next_st.full = xmov.ptr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Upper address bits are dropped, so the RAM repeats over the 64k range
    assign onchip_external_ram_addr      = st.full[ONCHIP_EXTERNAL_RAM_AW-1:0];
    assign onchip_external_ram_full_addr = st.full;
    assign onchip_external_ram_valid     = st.valid;

    short_page_a: assert property (@(posedge clk) disable iff (sys_rst)
        xmov.valid && xmov.short_addr |=> onchip_external_ram_valid && onchip_external_ram_full_addr == {7'h00, $past(page), $past(xmov.low)})
        else $error("short move address not built from page register");

    page_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        xmov.valid && xmov.short_addr && page |=> onchip_external_ram_full_addr >= 16'h0100 && onchip_external_ram_full_addr <= 16'h01FF)
        else $error("page one access outside 0x0100..0x01FF");

    long_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
        xmov.valid && !xmov.short_addr |=> onchip_external_ram_addr == $past(xmov.ptr[ONCHIP_EXTERNAL_RAM_AW-1:0]))
        else $error("pointer move did not wrap modulo RAM size");

endmodule

// ---- sim/sfd_core_model.sv ----
`timescale 1ns/1ns
module sfd_core_model (
    input  logic               clk,
    output sfd_pkg::sfd_acc_t  acc,
    output sfd_pkg::sfd_xmov_t xmov,
    output logic [7:0]         periph_rdata
);
    // Peripheral read data follows the address; while idle it drives the inverted write data
    assign periph_rdata = acc.valid ? (acc.addr ^ 8'h5A) : ~acc.wdata;

    initial begin
        acc  = '0;
        xmov = '0;
    end

    // One request, then release after the edge that takes it
    task automatic do_acc(input logic ind, bop, wr, input logic [7:0] a, d);
        @(posedge clk);
        // Callers keep to occupied addresses except where reserved handling is itself checked and in the bit-access sweep over 0x80..0xFF
        acc <= {1'b1, ind, bop, wr, a, d};
        @(posedge clk);
        acc.valid <= 1'b0;
    endtask

    task automatic do_xmov(input logic short_op, input logic [7:0] low, input logic [15:0] ptr);
        @(posedge clk);
        xmov <= {1'b1, short_op, low, ptr};
        @(posedge clk);
        xmov.valid <= 1'b0;
    endtask
endmodule

// ---- sim/sfd_sfr_decode_tb.sv ----
`timescale 1ns/1ns
module sfd_sfr_decode_tb;
    logic                clk;
    logic                sys_rst;
    sfd_pkg::sfd_acc_t   acc;
    sfd_pkg::sfd_xmov_t  xmov;
    logic [7:0]          periph_rdata;
    sfd_pkg::sfd_route_t route;
    logic [7:0]          rdata;
    logic                page_select_bit;
    logic [8:0]          onchip_external_ram_addr;
    logic [15:0]         onchip_external_ram_full_addr;
    logic                onchip_external_ram_valid;
    int                  fail_count;
    int                  compares;
    int                  cycles = 0;

    sfd_core_model i_sfd_core_model (.clk(clk), .acc(acc), .xmov(xmov), .periph_rdata(periph_rdata));

    sfd_sfr_decode #(.ONCHIP_EXTERNAL_RAM_AW(9)) i_sfd_sfr_decode (
        .clk(clk), .sys_rst(sys_rst), .acc(acc), .periph_rdata(periph_rdata), .xmov(xmov),
        .route(route), .rdata(rdata), .page_select_bit(page_select_bit), .onchip_external_ram_addr(onchip_external_ram_addr),
        .onchip_external_ram_full_addr(onchip_external_ram_full_addr), .onchip_external_ram_valid(onchip_external_ram_valid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Route bits: lo_ram hi_ram sfr periph reserved bit_refused page_hit
    task automatic acc_chk(input logic ind, bop, wr, input logic [7:0] a, d, input logic [6:0] er, input logic [7:0] ed);
        i_sfd_core_model.do_acc(ind, bop, wr, a, d);
        #1;
        chk("route", {9'h000, er}, {9'h000, route});
        chk("rdata", {8'h00, ed}, {8'h00, rdata});
    endtask

    task automatic xm_chk(input logic s, input logic [7:0] low, input logic [15:0] ptr, input logic [15:0] ef);
        i_sfd_core_model.do_xmov(s, low, ptr);
        #1;
        chk("onchip_external_ram_valid", 16'h0001, {15'h0000, onchip_external_ram_valid});
        chk("onchip_external_ram_full_addr", ef, onchip_external_ram_full_addr);
        chk("onchip_external_ram_addr", {7'h00, ef[8:0]}, {7'h00, onchip_external_ram_addr});
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        fail_count = 0;
        compares   = 0;
        sys_rst    = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("page reset", 16'h0000, {15'h0000, page_select_bit});
        chk("route reset", 16'h0000, {9'h000, route});
        acc_chk(1'b0, 1'b0, 1'b0, 8'h7F, 8'h00, 7'h40, 8'h00);
        acc_chk(1'b0, 1'b0, 1'b0, 8'h80, 8'h00, 7'h18, 8'hDA);
        acc_chk(1'b0, 1'b0, 1'b0, 8'hFF, 8'h00, 7'h18, 8'hA5);
        acc_chk(1'b1, 1'b0, 1'b0, 8'h80, 8'h00, 7'h20, 8'h00);
        acc_chk(1'b0, 1'b0, 1'b0, 8'h84, 8'h00, 7'h14, 8'h00);
        acc_chk(1'b0, 1'b0, 1'b1, 8'hAA, 8'hFF, 7'h11, 8'h00);
        chk("page", 16'h0001, {15'h0000, page_select_bit});
        acc_chk(1'b0, 1'b0, 1'b0, 8'hAA, 8'h00, 7'h11, 8'h01);
        acc_chk(1'b0, 1'b0, 1'b1, 8'hAB, 8'h00, 7'h14, 8'h00);
        acc_chk(1'b1, 1'b0, 1'b1, 8'hAA, 8'h00, 7'h20, 8'h00);
        acc_chk(1'b0, 1'b1, 1'b1, 8'hAA, 8'h00, 7'h12, 8'h00);
        chk("page kept", 16'h0001, {15'h0000, page_select_bit});
        xm_chk(1'b1, 8'h34, 16'hFFFF, 16'h0134);
        xm_chk(1'b0, 8'h34, 16'hFE34, 16'hFE34);
        acc_chk(1'b0, 1'b0, 1'b1, 8'hAA, 8'hFE, 7'h11, 8'h00);
        xm_chk(1'b1, 8'hC7, 16'h0000, 16'h00C7);
        for (int i = 0; i < 128; i++) begin
            i_sfd_core_model.do_acc(1'b0, 1'b1, 1'b0, 8'h80 | 8'(i), 8'h00);
            #1;
            chk("bit_refused", {15'h0000, (i % 8) != 0}, {15'h0000, route.bit_refused});
            if ((i % 8) != 0) begin
                chk("refused rdata", 16'h0000, {8'h00, rdata});
            end
        end
        finish_test();
    end
endmodule
